//--- hdlc_rx.sv
// hdlc overhead receive path: delineation, destuffing, fcs check,
// byte fifo and axi4-lite register slave
// assumes the overhead bit stream comes from framer logic on the same clock
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "hdlc_rx_defines.svh"

module hdlc_rx #(
  parameter int DEPTH = 256
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire hdlc_rx_pkg::line_in_type line_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  import hdlc_rx_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] DEPTH_C = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W:0] RESTART_FREE_C = (PTR_W + 1)'(`RESTART_FREE);

  // threshold byte lanes and the status count field need 256..32768
  generate
    if (DEPTH < 256 || DEPTH > 32768 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
      $error("hdlc_rx: DEPTH must be a power of two from 256 to 32768");
    end
  endgenerate

  function automatic reg_sel_type reg_decode(input logic [7:0] addr);
    case (addr)
      `CTRL_OFFSET: reg_decode = reg_ctrl;
      `THRESH_OFFSET: reg_decode = reg_thresh;
      `STATUS_OFFSET: reg_decode = reg_status;
      `DATA_OFFSET: reg_decode = reg_data;
      `INT_STATUS_OFFSET: reg_decode = reg_int_status;
      `INT_MASK_OFFSET: reg_decode = reg_int_mask;
      default: reg_decode = reg_none;
    endcase
  endfunction : reg_decode

  // reflected crc, first received bit of the octet sits in bit 7
  function automatic logic [15:0] crc_octet(input logic [15:0] crc, input logic [7:0] octet);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[0] ^ octet[i]) begin
        c = (c >> 1) ^ `CRC_POLY_REFLECTED;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction : crc_octet

  logic [2:0] ctrl_reg;
  logic [PTR_W:0] thresh_reg;
  logic [`INT_WIDTH-1:0] int_status_reg;
  logic [`INT_WIDTH-1:0] int_mask_reg;

  // line side
  rx_state_type state_reg;
  logic [2:0] ones_reg;
  logic [14:0] dsr_reg;
  logic [3:0] dcnt_reg;
  logic [4:0] fbits_reg;
  logic [2:0][7:0] hold_reg;
  logic [1:0] hcnt_reg;
  logic started_reg;
  logic fcs_on_reg;
  logic [15:0] crc_reg;

  logic b;
  logic in_frame;
  logic is_flag;
  logic is_abort;
  logic is_stuff;
  logic is_data;
  logic byte_done;
  logic [14:0] dsr_shift;
  logic [1:0] keep;
  logic [7:0] oldest;
  logic [7:0] oldest_rev;
  logic close_frame;
  logic short_frame;
  logic partial;
  logic crc_ok;

  assign b = line_in.bit_val ^ ctrl_reg[`CTRL_INVERT_BIT];
  assign in_frame = state_reg == frame_state;
  assign is_flag = line_in.valid && !b && ones_reg == `FLAG_ONES;
  assign is_abort = line_in.valid && b && ones_reg == `FLAG_ONES;
  assign is_stuff = line_in.valid && !b && ones_reg == `STUFF_ONES;
  assign is_data = line_in.valid && in_frame && !is_flag && !is_abort && !is_stuff;
  // the last seven bits may still turn out to be a flag, so bytes lag
  assign dsr_shift = {dsr_reg[13:0], b};
  assign byte_done = is_data && dcnt_reg == `BYTE_READY_COUNT;
  // holding two extra bytes lets the fcs be stripped without rewinding
  assign keep = fcs_on_reg ? 2'h3 : 2'h1;
  assign oldest = fcs_on_reg ? hold_reg[2] : hold_reg[0];
  assign close_frame = in_frame && is_flag;
  assign short_frame = fbits_reg < `MIN_FRAME_BITS;
  assign partial = dcnt_reg != `LOOKAHEAD_BITS;
  assign crc_ok = crc_reg == `CRC_GOOD_RESIDUE;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_rev
      assign oldest_rev[g] = oldest[7 - g];
    end
  endgenerate

  fifo_entry_type emit;
  logic emit_valid;
  logic ev_invalid;
  logic ev_abort;
  logic ev_fcs;

  always_comb begin
    emit_valid = 1'b0;
    emit = '0;
    ev_invalid = 1'b0;
    ev_abort = 1'b0;
    ev_fcs = 1'b0;
    emit.data = ctrl_reg[`CTRL_REORDER_BIT] ? oldest : oldest_rev;
    if (byte_done && hcnt_reg == keep) begin
      emit_valid = 1'b1;
      emit.pkt_start = !started_reg;
    end
    if (close_frame && !short_frame) begin
      if (partial) begin
        ev_invalid = 1'b1;
        emit_valid = started_reg;
        emit.pkt_end = 1'b1;
        emit.abort = 1'b1;
      end else if (started_reg) begin
        emit_valid = 1'b1;
        emit.pkt_end = 1'b1;
        emit.fcs_err = fcs_on_reg && !crc_ok;
        ev_fcs = fcs_on_reg && !crc_ok;
      end
    end
    // six ones right after a flag are idle fill, not a broken packet
    if (in_frame && is_abort) begin
      ev_abort = fbits_reg > {2'h0, `FLAG_ONES};
      emit_valid = started_reg;
      emit.pkt_end = 1'b1;
      emit.abort = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_reg <= hunt_state;
    end else if (is_flag) begin
      state_reg <= frame_state;
    end else if (is_abort) begin
      state_reg <= hunt_state;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ones_reg <= 3'h0;
    end else if (line_in.valid) begin
      if (!b) begin
        ones_reg <= 3'h0;
      end else if (ones_reg != `MAX_ONES) begin
        ones_reg <= ones_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      dsr_reg <= '0;
      dcnt_reg <= 4'h0;
      fbits_reg <= 5'h0;
      hold_reg <= '0;
      hcnt_reg <= 2'h0;
      started_reg <= 1'b0;
      fcs_on_reg <= 1'b0;
      crc_reg <= `CRC_INIT;
    end else if (is_flag) begin
      dcnt_reg <= 4'h0;
      fbits_reg <= 5'h0;
      hcnt_reg <= 2'h0;
      started_reg <= 1'b0;
      fcs_on_reg <= ctrl_reg[`CTRL_FCS_BIT];
      crc_reg <= `CRC_INIT;
    end else if (is_data) begin
      dsr_reg <= dsr_shift;
      if (fbits_reg != `MAX_FRAME_BITS) begin
        fbits_reg <= fbits_reg + 5'h1;
      end
      if (byte_done) begin
        dcnt_reg <= `LOOKAHEAD_BITS;
        crc_reg <= crc_octet(crc_reg, dsr_shift[14:7]);
        hold_reg <= {hold_reg[1:0], dsr_shift[14:7]};
        if (hcnt_reg == keep) begin
          started_reg <= 1'b1;
        end else begin
          hcnt_reg <= hcnt_reg + 2'h1;
        end
      end else begin
        dcnt_reg <= dcnt_reg + 4'h1;
      end
    end
  end

  // receive fifo
  fifo_entry_type mem [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic drop_reg;
  logic [PTR_W:0] free_space;
  logic full;
  logic empty;
  logic accept;
  logic ovf;
  logic mark_abort;
  logic pop;

  // register bus handshakes
  logic wr_fire;
  logic rd_fire;
  reg_sel_type wr_sel;
  reg_sel_type rd_sel;

  assign free_space = DEPTH_C - count_reg;
  assign full = count_reg == DEPTH_C;
  assign empty = count_reg == '0;
  assign accept = emit_valid &&
    (drop_reg ? (emit.pkt_start && free_space >= RESTART_FREE_C) : !full);
  assign ovf = emit_valid && !drop_reg && full;
  // full means many bytes stored, so the last written one is still unread
  assign mark_abort = ovf && !emit.pkt_start;
  assign pop = rd_fire && rd_sel == reg_data && !empty;

  always_ff @(posedge clock) begin
    if (accept) begin
      mem[wr_ptr_reg] <= emit;
    end else if (mark_abort) begin
      mem[PTR_W'(wr_ptr_reg - 1'b1)].abort <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (accept) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (accept && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !accept) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      drop_reg <= 1'b0;
    end else if (ovf) begin
      drop_reg <= 1'b1;
    end else if (drop_reg && accept) begin
      drop_reg <= 1'b0;
    end
  end

  // axi4-lite slave: both write channels taken in one beat, one at a time
  assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign rd_fire = s_axi_arready && s_axi_arvalid;
  assign wr_sel = reg_decode(s_axi_awaddr);
  assign rd_sel = reg_decode(s_axi_araddr);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == reg_none) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_reg <= `CTRL_RESET;
      thresh_reg <= (PTR_W + 1)'(`THRESH_RESET);
      int_mask_reg <= '0;
    end else if (wr_fire) begin
      if (wr_sel == reg_ctrl && s_axi_wstrb[0]) begin
        ctrl_reg <= s_axi_wdata[2:0];
      end
      if (wr_sel == reg_thresh && s_axi_wstrb[0]) begin
        thresh_reg[7:0] <= s_axi_wdata[7:0];
      end
      if (wr_sel == reg_thresh && s_axi_wstrb[1]) begin
        thresh_reg[PTR_W:8] <= s_axi_wdata[PTR_W:8];
      end
      if (wr_sel == reg_int_mask && s_axi_wstrb[0]) begin
        int_mask_reg <= s_axi_wdata[`INT_WIDTH-1:0];
      end
    end
  end

  // sticky events; a new event beats a write-one-to-clear in the same cycle
  logic [`INT_WIDTH-1:0] events;
  logic [`INT_WIDTH-1:0] clear_bits;

  always_comb begin
    events = '0;
    events[`INT_OVERFLOW_BIT] = ovf;
    events[`INT_INVALID_BIT] = ev_invalid;
    events[`INT_ABORT_BIT] = ev_abort;
    events[`INT_FCS_BIT] = ev_fcs;
    events[`INT_PACKET_BIT] = accept && emit.pkt_end;
    clear_bits = '0;
    if (wr_fire && wr_sel == reg_int_status && s_axi_wstrb[0]) begin
      clear_bits = s_axi_wdata[`INT_WIDTH-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      int_status_reg <= '0;
      irq <= 1'b0;
    end else begin
      int_status_reg <= (int_status_reg & ~clear_bits) | events;
      irq <= |(int_status_reg & int_mask_reg);
    end
  end

  logic [31:0] rd_word;

  always_comb begin
    rd_word = '0;
    case (rd_sel)
      reg_ctrl: rd_word[2:0] = ctrl_reg;
      reg_thresh: rd_word[PTR_W:0] = thresh_reg;
      reg_status: begin
        rd_word[`STAT_EMPTY_BIT] = empty;
        rd_word[`STAT_AVAIL_BIT] = count_reg >= thresh_reg;
        rd_word[`STAT_FULL_BIT] = full;
        rd_word[`STAT_COUNT_LSB +: PTR_W + 1] = count_reg;
      end
      reg_data: begin
        if (!empty) begin
          rd_word[11:0] = mem[rd_ptr_reg];
          rd_word[`DATA_VALID_BIT] = 1'b1;
        end
      end
      reg_int_status: rd_word[`INT_WIDTH-1:0] = int_status_reg;
      reg_int_mask: rd_word[`INT_WIDTH-1:0] = int_mask_reg;
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (rd_sel == reg_none) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  property p_invert_ones;
    @(posedge clock) disable iff (!rst_b)
      line_in.valid && (line_in.bit_val ^ ctrl_reg[`CTRL_INVERT_BIT]) |=> ones_reg != 3'h0;
  endproperty
  a_invert_ones: assert property (p_invert_ones) else $error("inverted one not counted");

  property p_flag_opens;
    @(posedge clock) disable iff (!rst_b)
      is_flag |=> state_reg == frame_state && fbits_reg == 5'h0 && !started_reg;
  endproperty
  a_flag_opens: assert property (p_flag_opens) else $error("flag did not open frame");

  property p_short_dropped;
    @(posedge clock) disable iff (!rst_b)
      close_frame && short_frame |-> !emit_valid && !ev_invalid;
  endproperty
  a_short_dropped: assert property (p_short_dropped) else $error("short frame delivered");

  property p_abort_hunt;
    @(posedge clock) disable iff (!rst_b)
      in_frame && is_abort |=> state_reg == hunt_state && ones_reg == `MAX_ONES;
  endproperty
  a_abort_hunt: assert property (p_abort_hunt) else $error("abort did not end frame");

  property p_stuff_deleted;
    @(posedge clock) disable iff (!rst_b)
      in_frame && is_stuff |=> $stable(dcnt_reg) && $stable(fbits_reg);
  endproperty
  a_stuff_deleted: assert property (p_stuff_deleted) else $error("stuffed zero kept");

  property p_invalid_status;
    @(posedge clock) disable iff (!rst_b)
      close_frame && !short_frame && partial |=> int_status_reg[`INT_INVALID_BIT];
  endproperty
  a_invalid_status: assert property (p_invalid_status) else $error("invalid not flagged");

  property p_fcs_result;
    @(posedge clock) disable iff (!rst_b)
      emit_valid && emit.pkt_end && !emit.abort |-> emit.fcs_err == (fcs_on_reg && !crc_ok);
  endproperty
  a_fcs_result: assert property (p_fcs_result) else $error("fcs error mark wrong");

  property p_start_overflow;
    @(posedge clock) disable iff (!rst_b)
      emit_valid && emit.pkt_start && full && !drop_reg
      |=> drop_reg && $stable(wr_ptr_reg) ##1 int_status_reg[`INT_OVERFLOW_BIT];
  endproperty
  a_start_overflow: assert property (p_start_overflow) else $error("overflow not handled");

  property p_drop_hold;
    @(posedge clock) disable iff (!rst_b)
      drop_reg && emit_valid && !(emit.pkt_start && free_space >= RESTART_FREE_C)
      |=> $stable(wr_ptr_reg) && drop_reg;
  endproperty
  a_drop_hold: assert property (p_drop_hold) else $error("byte stored while dropping");

  property p_empty_read;
    @(posedge clock) disable iff (!rst_b)
      rd_fire && rd_sel == reg_data && empty
      |=> s_axi_rvalid && !s_axi_rdata[`DATA_VALID_BIT] && $stable(rd_ptr_reg);
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty read misreported");

endmodule : hdlc_rx
`default_nettype wire

//--- hdlc_rx_defines.svh
// register offsets, field positions, reset values and line constants
// for the hdlc overhead receive path; included by the design module
`ifndef HDLC_RX_DEFINES_SVH
`define HDLC_RX_DEFINES_SVH

`define CTRL_OFFSET 8'h00
`define THRESH_OFFSET 8'h04
`define STATUS_OFFSET 8'h08
`define DATA_OFFSET 8'h0c
`define INT_STATUS_OFFSET 8'h10
`define INT_MASK_OFFSET 8'h14

`define CTRL_INVERT_BIT 0
`define CTRL_FCS_BIT 1
`define CTRL_REORDER_BIT 2
`define CTRL_RESET 3'h2
`define THRESH_RESET 16'h0010

`define STAT_EMPTY_BIT 0
`define STAT_AVAIL_BIT 1
`define STAT_FULL_BIT 2
`define STAT_COUNT_LSB 16
`define DATA_VALID_BIT 15

`define INT_OVERFLOW_BIT 0
`define INT_INVALID_BIT 1
`define INT_ABORT_BIT 2
`define INT_FCS_BIT 3
`define INT_PACKET_BIT 4
`define INT_WIDTH 5

`define FLAG_ONES 3'h6
`define STUFF_ONES 3'h5
`define MAX_ONES 3'h7
`define LOOKAHEAD_BITS 4'h7
`define BYTE_READY_COUNT 4'he
`define MIN_FRAME_BITS 5'h17
`define MAX_FRAME_BITS 5'h1f
`define RESTART_FREE 16'h0010

`define CRC_INIT 16'hffff
`define CRC_POLY_REFLECTED 16'h8408
`define CRC_GOOD_RESIDUE 16'hf0b8

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- hdlc_rx_pkg.sv
// types shared by the hdlc overhead receive path
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package hdlc_rx_pkg;

  typedef enum logic {
    hunt_state = 1'b0,
    frame_state = 1'b1
  } rx_state_type;

  typedef enum logic [2:0] {
    reg_ctrl = 3'h0,
    reg_thresh = 3'h1,
    reg_status = 3'h2,
    reg_data = 3'h3,
    reg_int_status = 3'h4,
    reg_int_mask = 3'h5,
    reg_none = 3'h6
  } reg_sel_type;

  typedef struct packed {
    logic fcs_err;
    logic abort;
    logic pkt_end;
    logic pkt_start;
    logic [7:0] data;
  } fifo_entry_type;

  typedef struct packed {
    logic bit_val;
    logic valid;
  } line_in_type;

endpackage : hdlc_rx_pkg
`default_nettype wire

//--- hdlc_rx_framer_model.sv
// serial overhead source standing in for the framer feeding hdlc_rx
// assumes hdlc_rx samples line_in on the same rising clock edge
`timescale 1ns/10ps
`default_nettype none
module hdlc_rx_framer_model (
  input wire logic clock,
  output var hdlc_rx_pkg::line_in_type line_in
);
  import hdlc_rx_pkg::*;
  logic vld;
  logic bv;
  logic noise;
  logic inv;
  logic slow;
  logic [15:0] crc;
  int ones;
  initial begin
    vld = 1'b0;
    bv = 1'b0;
    inv = 1'b0;
    slow = 1'b0;
    crc = 16'hffff;
  end
  // idle line toggles so a stale bit can never look valid
  always @(posedge clock) noise <= (noise !== 1'b1);
  assign line_in = '{bit_val: vld ? bv : noise, valid: vld};
  task automatic put(input logic b);
    @(posedge clock);
    vld <= 1'b1;
    bv <= b ^ inv;
    if (slow) begin
      @(posedge clock);
      vld <= 1'b0;
    end
  endtask : put
  task automatic raw(input logic [15:0] b, input int n);
    for (int i = 0; i < n; i++) put(b[i]);
    ones = 0;
  endtask : raw
  task automatic data(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      put(b[i]);
      crc = (crc >> 1) ^ ((crc[0] ^ b[i]) ? 16'h8408 : 16'h0000);
      ones = b[i] ? ones + 1 : 0;
      if (ones == 5) begin
        put(1'b0);
        ones = 0;
      end
    end
  endtask : data
  task automatic open_frame();
    raw(16'h007e, 8);
    crc = 16'hffff;
  endtask : open_frame
  task automatic close_frame(input logic bad, input logic with_fcs);
    logic [15:0] fcs;
    fcs = ~crc ^ {15'h0000, bad};
    if (with_fcs) begin
      data(fcs[7:0]);
      data(fcs[15:8]);
    end
    raw(16'h007e, 8);
    // ones fill of odd length
    raw(16'hffff, 11);
    @(posedge clock);
    vld <= 1'b0;
  endtask : close_frame
endmodule : hdlc_rx_framer_model
`default_nettype wire

//--- hdlc_overhead_receive_path_bench.sv
// self-checking bench for hdlc_rx: axi4-lite master plus framer model
// assumes the register map and bus timing of hdlc_rx
`timescale 1ns/10ps
`default_nettype none
`include "hdlc_rx_defines.svh"
module hdlc_overhead_receive_path_bench;
  import hdlc_rx_pkg::*;
  logic clock;
  logic rst_b;
  line_in_type line_in;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic awvalid;
  logic wvalid;
  logic bready;
  logic arvalid;
  logic rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int fails;
  int check_count;
  hdlc_rx #(.DEPTH(256)) uut (.clock(clock), .rst_b(rst_b), .line_in(line_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  hdlc_rx_framer_model far (.clock(clock), .line_in(line_in));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  initial begin
    #400000;
    fails++;
    conclude();
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clock);
      if (awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    bready <= 1'b1;
    do @(posedge clock); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clock); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask : w
  task automatic ex(input string what, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(what, exp, d & m);
  endtask : ex
  // pops until the invalid indication; returns last valid word and count
  task automatic drain(output logic [31:0] last, output int n);
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    last = 32'h0;
    for (int i = 0; i < 300; i++) begin
      rd(`DATA_OFFSET, d, r);
      if (d[15] !== 1'b1) break;
      last = d;
      n++;
    end
  endtask : drain
  task automatic reset_values();
    logic [31:0] d;
    logic [1:0] r;
    ex("ctrl", `CTRL_OFFSET, 32'hffffffff, 32'h2);
    ex("thresh", `THRESH_OFFSET, 32'hffffffff, 32'h10);
    ex("status", `STATUS_OFFSET, 32'hffffffff, 32'h1);
    ex("mask", `INT_MASK_OFFSET, 32'hffffffff, 32'h0);
    // byte lanes of the threshold are written one at a time
    wstrb <= 4'h1;
    w(`THRESH_OFFSET, 32'h1ff);
    ex("thresh lane 0", `THRESH_OFFSET, 32'hffffffff, 32'hff);
    wstrb <= 4'h2;
    w(`THRESH_OFFSET, 32'h100);
    ex("thresh lane 1", `THRESH_OFFSET, 32'hffffffff, 32'h1ff);
    wstrb <= 4'hf;
    w(`THRESH_OFFSET, 32'h10);
    rd(8'h20, d, r);
    check("unmapped read", 32'h2, {d[29:0], r});
    wr(8'h20, 32'h1, r);
    check("unmapped write", 32'h2, {30'h0, r});
  endtask : reset_values
  task automatic good_frame(input logic s);
    far.slow = s;
    far.open_frame();
    far.data(8'hff);
    far.data(8'h7e);
    far.close_frame(1'b0, 1'b1);
    far.slow = 1'b0;
    ex("byte 0", `DATA_OFFSET, 32'hffffffff, 32'h81ff);
    ex("byte 1", `DATA_OFFSET, 32'hffffffff, 32'h827e);
    ex("empty pop", `DATA_OFFSET, 32'hffffffff, 32'h0);
    ex("packet irq", `INT_STATUS_OFFSET, 32'h10, 32'h10);
    check("irq masked", 32'h0, {31'h0, irq});
  endtask : good_frame
  task automatic bad_fcs();
    w(`INT_MASK_OFFSET, 32'h8);
    far.open_frame();
    far.data(8'h12);
    far.data(8'h34);
    far.close_frame(1'b1, 1'b1);
    ex("bad byte 0", `DATA_OFFSET, 32'hffffffff, 32'h8112);
    ex("bad byte 1", `DATA_OFFSET, 32'hffffffff, 32'h8a34);
    check("irq raised", 32'h1, {31'h0, irq});
    w(`INT_STATUS_OFFSET, 32'h1f);
    repeat (3) @(posedge clock);
    check("irq cleared", 32'h0, {31'h0, irq});
    w(`INT_MASK_OFFSET, 32'h0);
  endtask : bad_fcs
  task automatic invert_reorder();
    w(`CTRL_OFFSET, 32'h5);
    far.inv = 1'b1;
    far.open_frame();
    far.data(8'h01);
    far.data(8'h0f);
    far.data(8'h55);
    far.close_frame(1'b0, 1'b0);
    far.inv = 1'b0;
    ex("rev 0", `DATA_OFFSET, 32'hffffffff, 32'h8180);
    ex("rev 1", `DATA_OFFSET, 32'hffffffff, 32'h80f0);
    ex("rev 2", `DATA_OFFSET, 32'hffffffff, 32'h82aa);
    w(`CTRL_OFFSET, 32'h2);
  endtask : invert_reorder
  task automatic short_frame();
    far.open_frame();
    far.data(8'h55);
    far.close_frame(1'b0, 1'b0);
    ex("short dropped", `STATUS_OFFSET, 32'hffffffff, 32'h1);
  endtask : short_frame
  task automatic abort_frame();
    logic [31:0] last;
    int n;
    w(`INT_STATUS_OFFSET, 32'h1f);
    far.open_frame();
    for (int i = 0; i < 6; i++) far.data(8'ha5);
    far.raw(16'h00ff, 8);
    far.close_frame(1'b0, 1'b0);
    ex("abort irq", `INT_STATUS_OFFSET, 32'h4, 32'h4);
    drain(last, n);
    check("abort tag", 32'h8400, last & 32'h8400);
  endtask : abort_frame
  task automatic partial();
    logic [31:0] last;
    int n;
    w(`INT_STATUS_OFFSET, 32'h1f);
    w(`CTRL_OFFSET, 32'h0);
    far.open_frame();
    far.data(8'h11);
    far.data(8'h22);
    far.data(8'h33);
    far.raw(16'h0000, 3);
    far.close_frame(1'b0, 1'b0);
    ex("invalid irq", `INT_STATUS_OFFSET, 32'h2, 32'h2);
    drain(last, n);
    check("partial tag", 32'h8400, last & 32'h8400);
  endtask : partial
  // 256 bytes fill the fifo exactly; more overflow inside the packet
  task automatic overflow(input int len);
    logic [31:0] last;
    int n;
    w(`INT_STATUS_OFFSET, 32'h1f);
    far.open_frame();
    for (int i = 0; i < len; i++) far.data(8'h00);
    far.close_frame(1'b0, 1'b0);
    ex("full", `STATUS_OFFSET, 32'hffffffff, 32'h01000006);
    ex("early overflow irq", `INT_STATUS_OFFSET, 32'h1, {31'h0, len > 256});
    far.open_frame();
    far.data(8'h99);
    far.data(8'h99);
    far.close_frame(1'b0, 1'b0);
    ex("overflow irq", `INT_STATUS_OFFSET, 32'h1, 32'h1);
    drain(last, n);
    check("stored count", 32'd256, n);
    check("overflow tag", len > 256 ? 32'h8400 : 32'h8000, last & 32'h8400);
    far.open_frame();
    far.data(8'h3c);
    far.data(8'h3c);
    far.close_frame(1'b0, 1'b0);
    ex("resume 0", `DATA_OFFSET, 32'hffffffff, 32'h813c);
    ex("resume 1", `DATA_OFFSET, 32'hffffffff, 32'h823c);
  endtask : overflow
  initial begin
    rst_b <= 1'b0;
    awaddr <= 8'h00;
    araddr <= 8'h00;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    wdata <= 32'h0;
    wstrb <= 4'hf;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    reset_values();
    good_frame(1'b0);
    good_frame(1'b1);
    bad_fcs();
    invert_reorder();
    short_frame();
    abort_frame();
    partial();
    overflow(258);
    overflow(256);
    conclude();
  end
endmodule : hdlc_overhead_receive_path_bench
`default_nettype wire
